/* rtl/access_point_ctrl.sv */
// Function
// - terminal decodes modes robust up to granted
// - either side may start mode change
// - terminal request never carries zero mode
// - 3-bit mode field, 0 none, 7 reserved
// - acknowledgement echoes announced mode value
// - robust switch happens on report receipt
// - efficient switch only after full handshake
// - access point starts change only on new
// - resend announcement on ack timer expiry
// - terminal resends report on response timeout
// - terminal always acknowledges any announcement
// - uplink power step within allowed limits
// - correction has power, timing, request fields
// - terminal answers correction with fresh report
// - resend correction on report timer expiry
// - correction report with new mode starts handshake
// - raise downlink power only for robust need
// - apply downlink power change before preamble
// - downlink change max 1 dB per 50 ms
// - downlink step below threshold gap, up to 1 dB when the gap is zero
// - maximum uplink power limit confirmed, lowerable; not implemented, only the correction step is clamped to PWR_INC_MAX
// - report field order and widths fixed
`timescale 1ns/10ps
`default_nettype none
module access_point_ctrl #(
    parameter int DL_WINDOW = link_adapt_pkg::DL_WINDOW_CYC
) (
    // clock and reset
    input  wire logic                                   clk_i,
    input  wire logic                                   resetn_i,
    // link
    link_adapt_if.access_point                          link,
    // mode control from scheduler
    input  wire logic                                   cmd_mode_valid_i,
    input  wire logic [link_adapt_pkg::MODE_W-1:0]      cmd_mode_i,
    input  wire logic [link_adapt_pkg::TIMER_W-1:0]     ack_timeout_i,
    // uplink correction request
    input  wire logic                                   cmd_corr_valid_i,
    input  wire logic [link_adapt_pkg::PWR_INC_W-1:0]   cmd_corr_power_i,
    input  wire logic [link_adapt_pkg::TIMING_W-1:0]    cmd_corr_timing_i,
    input  wire logic                                   cmd_corr_report_req_i,
    input  wire logic                                   ranging_i,
    input  wire logic [link_adapt_pkg::TIMER_W-1:0]     corr_timeout_i,
    // downlink power control
    input  wire logic                                   preamble_i,
    input  wire logic                                   robust_short_i,
    input  wire logic [link_adapt_pkg::DL_PWR_W-1:0]    dl_power_target_i,
    input  wire logic [link_adapt_pkg::DL_PWR_W-1:0]    threshold_gap_i,
    // status
    output logic [link_adapt_pkg::MODE_W-1:0]           current_mode_o,
    output logic                                        busy_o,
    output logic                                        report_o,
    output logic [link_adapt_pkg::REPORT_W-1:0]         report_data_o,
    output logic [link_adapt_pkg::DL_PWR_W-1:0]         dl_power_o
);
    import link_adapt_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_ACK} ap_state_t;

    ap_state_t                state_reg;
    logic [MODE_W-1:0]        granted_reg;
    logic [MODE_W-1:0]        wanted;
    logic                     wanted_valid;
    logic                     start_ann;
    logic                     ack_ok;
    logic                     ann_expired;
    logic                     corr_expired;
    logic                     corr_pending;
    logic [PWR_INC_W-1:0]     corr_power_reg;
    logic [TIMING_W-1:0]      corr_timing_reg;
    logic                     corr_req_reg;
    logic [PWR_INC_W-1:0]     power_min;
    logic [PWR_INC_W-1:0]     power_clamped;
    logic [DL_PWR_W-1:0]      dl_used_reg;
    logic [31:0]              dl_win_reg;
    logic [DL_PWR_W-1:0]      step_lim;
    logic [DL_PWR_W-1:0]      step;
    logic                     dl_quiet;
    logic [DL_PWR_W-1:0]      dl_budget;

    // wanted mode sits in the top field of the report
    assign wanted       = link.report[REPORT_W-1 -: MODE_W];
    assign wanted_valid = link.report_valid && wanted != MODE_NONE && wanted <= MODE_MAX;
    assign ack_ok       = state_reg == WAIT_ACK && link.ack_valid && link.ack_mode == granted_reg;
    assign start_ann    = state_reg == IDLE && (wanted_valid ||
                          (cmd_mode_valid_i && cmd_mode_i != MODE_NONE && cmd_mode_i <= MODE_MAX));

    retry_timer #(.W(TIMER_W)) u_ann_timer (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .start_i    (start_ann || (ann_expired && state_reg == WAIT_ACK && !ack_ok)),
        .cancel_i   (ack_ok),
        .duration_i (ack_timeout_i),
        .running_o  (),
        .expired_o  (ann_expired)
    );

    // announcement and mode switch ordering
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg      <= IDLE;
            granted_reg    <= MODE_ROBUST;
            current_mode_o <= MODE_ROBUST;
            link.ann_valid <= 1'b0;
            link.ann_mode  <= MODE_NONE;
            busy_o         <= 1'b0;
        end else begin
            link.ann_valid <= 1'b0;
            case (state_reg)
                IDLE: begin
                    if (start_ann) begin
                        granted_reg    <= wanted_valid ? wanted : cmd_mode_i;
                        link.ann_mode  <= wanted_valid ? wanted : cmd_mode_i;
                        link.ann_valid <= 1'b1;
                        busy_o         <= 1'b1;
                        state_reg      <= WAIT_ACK;
                        if (wanted_valid && wanted < current_mode_o)
                            current_mode_o <= wanted;
                        else if (!wanted_valid && cmd_mode_i < current_mode_o)
                            current_mode_o <= cmd_mode_i;
                    end
                end
                WAIT_ACK: begin
                    if (ack_ok) begin
                        current_mode_o <= granted_reg;
                        busy_o         <= 1'b0;
                        state_reg      <= IDLE;
                    end else if (ann_expired) begin
                        link.ann_valid <= 1'b1;
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // uplink correction, clamped to the allowed step range
    assign power_min     = ranging_i ? PWR_INC_MIN_RANGING : PWR_INC_MIN_NORMAL;
    assign power_clamped = cmd_corr_power_i < power_min ? power_min :
                           cmd_corr_power_i > PWR_INC_MAX ? PWR_INC_MAX : cmd_corr_power_i;

    retry_timer #(.W(TIMER_W)) u_corr_timer (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .start_i    ((cmd_corr_valid_i && !corr_pending) || (corr_expired && !link.report_valid)),
        .cancel_i   (link.report_valid),
        .duration_i (corr_timeout_i),
        .running_o  (corr_pending),
        .expired_o  (corr_expired)
    );

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link.corr_valid      <= 1'b0;
            link.corr_power      <= PWR_INC_ZERO;
            link.corr_timing     <= '0;
            link.corr_report_req <= REPORT_NOT_REQ;
            corr_power_reg       <= PWR_INC_ZERO;
            corr_timing_reg      <= '0;
            corr_req_reg         <= REPORT_NOT_REQ;
        end else begin
            link.corr_valid <= 1'b0;
            if (cmd_corr_valid_i && !corr_pending) begin
                corr_power_reg       <= power_clamped;
                corr_timing_reg      <= cmd_corr_timing_i;
                corr_req_reg         <= cmd_corr_report_req_i;
                link.corr_power      <= power_clamped;
                link.corr_timing     <= cmd_corr_timing_i;
                link.corr_report_req <= cmd_corr_report_req_i;
                link.corr_valid      <= 1'b1;
            end else if (corr_expired && !link.report_valid) begin
                link.corr_power      <= corr_power_reg;
                link.corr_timing     <= corr_timing_reg;
                link.corr_report_req <= corr_req_reg;
                link.corr_valid      <= 1'b1;
            end
        end
    end

    // received reports passed to the scheduler
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            report_o      <= 1'b0;
            report_data_o <= '0;
        end else begin
            report_o <= link.report_valid;
            if (link.report_valid)
                report_data_o <= link.report;
        end
    end

    // downlink power: per-step limit is the tighter of 1 dB and one step below the threshold gap (1 dB when the gap is zero)
    assign step_lim = (threshold_gap_i > 8'h00 && threshold_gap_i - 8'h01 < DL_STEP_MAX) ?
                      threshold_gap_i - 8'h01 : DL_STEP_MAX;

    // budget refills only after a full quiet window, so no window ever holds two batches
    assign dl_quiet  = dl_win_reg >= 32'(DL_WINDOW);
    assign dl_budget = dl_quiet ? DL_STEP_MAX : DL_STEP_MAX - dl_used_reg;

    always_comb begin
        step = '0;
        if (dl_power_target_i > dl_power_o && robust_short_i)
            step = dl_power_target_i - dl_power_o;
        else if (dl_power_target_i < dl_power_o)
            step = dl_power_o - dl_power_target_i;
        if (step > step_lim)
            step = step_lim;
        if (step > dl_budget)
            step = dl_budget;
    end

    // window counts from the last applied step and saturates once quiet
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dl_power_o  <= '0;
            dl_used_reg <= '0;
            dl_win_reg  <= '0;
        end else begin
            if (preamble_i && step != 8'h00) begin
                dl_win_reg  <= '0;
                dl_used_reg <= (dl_quiet ? 8'h00 : dl_used_reg) + step;
                dl_power_o  <= dl_power_target_i > dl_power_o ? dl_power_o + step
                                                              : dl_power_o - step;
            end else if (!dl_quiet) begin
                dl_win_reg <= dl_win_reg + 32'h1;
            end
        end
    end
endmodule : access_point_ctrl
`default_nettype wire

/* rtl/link_adapt_pkg.sv */
package link_adapt_pkg;

    // downlink mode field
    localparam int          MODE_W              = 3;
    localparam logic [2:0]  MODE_NONE           = 3'h0;
    localparam logic [2:0]  MODE_ROBUST         = 3'h1;
    localparam logic [2:0]  MODE_MAX            = 3'h4;
    localparam logic [2:0]  MODE_RESERVED       = 3'h7;

    // uplink correction message fields
    localparam int          PWR_INC_W           = 6;
    localparam int          TIMING_W            = 5;
    localparam logic        REPORT_NOT_REQ      = 1'b0;
    // power increment coded in 0.5 dB steps, offset so 40 means 0 dB
    localparam logic [5:0]  PWR_INC_ZERO        = 6'h28;
    localparam logic [5:0]  PWR_INC_MIN_RANGING = 6'h00;
    localparam logic [5:0]  PWR_INC_MIN_NORMAL  = 6'h20;
    localparam logic [5:0]  PWR_INC_MAX         = 6'h30;

    // measurement report fields
    localparam int          SNR_W               = 8;
    localparam int          RXP_W               = 8;
    localparam int          TXP_W               = 6;
    localparam int          MARGIN_W            = 6;
    localparam int          UL_MODE_W           = 3;
    localparam int          REPORT_W            = MODE_W + SNR_W + RXP_W + TXP_W + MARGIN_W + UL_MODE_W;

    // downlink power, 0.25 dB steps
    localparam int          DL_PWR_W            = 8;
    localparam logic [7:0]  DL_STEP_MAX         = 8'h04;
    localparam int          DL_WINDOW_MS        = 50;
    localparam int          CLK_KHZ             = 40000;
    localparam int          DL_WINDOW_CYC       = DL_WINDOW_MS * CLK_KHZ;

    localparam int          TIMER_W             = 24;

endpackage : link_adapt_pkg

/* rtl/link_adapt_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface link_adapt_if;
    import link_adapt_pkg::*;
    // downlink messages
    logic                   ann_valid;
    logic [MODE_W-1:0]      ann_mode;
    logic                   corr_valid;
    logic [PWR_INC_W-1:0]   corr_power;
    logic [TIMING_W-1:0]    corr_timing;
    logic                   corr_report_req;
    // uplink messages
    logic                   ack_valid;
    logic [MODE_W-1:0]      ack_mode;
    logic                   report_valid;
    logic [REPORT_W-1:0]    report;

    modport access_point (output ann_valid, ann_mode, corr_valid, corr_power, corr_timing, corr_report_req,
                          input ack_valid, ack_mode, report_valid, report);
    modport terminal     (input ann_valid, ann_mode, corr_valid, corr_power, corr_timing, corr_report_req,
                          output ack_valid, ack_mode, report_valid, report);
endinterface : link_adapt_if
`default_nettype wire

/* rtl/retry_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module retry_timer #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // control
    input  wire logic         start_i,
    input  wire logic         cancel_i,
    input  wire logic [W-1:0] duration_i,
    // status
    output logic              running_o,
    output logic              expired_o
);
    logic [W-1:0] count_reg;

    // cancel wins over expiry so a late answer never triggers a resend
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= '0;
            running_o <= 1'b0;
            expired_o <= 1'b0;
        end else begin
            expired_o <= 1'b0;
            if (start_i) begin
                count_reg <= duration_i;
                running_o <= 1'b1;
            end else if (cancel_i) begin
                running_o <= 1'b0;
            end else if (running_o) begin
                if (count_reg <= W'(1)) begin
                    running_o <= 1'b0;
                    expired_o <= 1'b1;
                end else begin
                    count_reg <= count_reg - W'(1);
                end
            end
        end
    end
endmodule : retry_timer
`default_nettype wire

/* rtl/terminal_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module terminal_ctrl (
    // clock and reset
    input  wire logic                                   clk_i,
    input  wire logic                                   resetn_i,
    // link
    link_adapt_if.terminal                              link,
    // measurement side
    input  wire logic                                   req_valid_i,
    input  wire logic [link_adapt_pkg::MODE_W-1:0]      req_mode_i,
    input  wire logic [link_adapt_pkg::REPORT_W-link_adapt_pkg::MODE_W-1:0] meas_i,
    input  wire logic [link_adapt_pkg::TIMER_W-1:0]     report_timeout_i,
    // status
    output logic [link_adapt_pkg::MODE_W-1:0]           decode_max_mode_o,
    output logic                                        corr_o,
    output logic [link_adapt_pkg::PWR_INC_W-1:0]        corr_power_o,
    output logic [link_adapt_pkg::TIMING_W-1:0]         corr_timing_o
);
    import link_adapt_pkg::*;

    logic               req_ok;
    logic               rep_expired;
    logic               rep_pending;
    logic [MODE_W-1:0]  req_mode_reg;
    logic               send_req;

    assign req_ok   = req_valid_i && req_mode_i != MODE_NONE && req_mode_i <= MODE_MAX;
    assign send_req = req_ok && !rep_pending;

    retry_timer #(.W(TIMER_W)) u_rep_timer (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .start_i    (send_req || (rep_expired && !link.ann_valid)),
        .cancel_i   (link.ann_valid),
        .duration_i (report_timeout_i),
        .running_o  (rep_pending),
        .expired_o  (rep_expired)
    );

    // decoded modes: robust one up to the granted highest
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            decode_max_mode_o <= MODE_ROBUST;
            link.ack_valid    <= 1'b0;
            link.ack_mode     <= MODE_NONE;
        end else begin
            link.ack_valid <= link.ann_valid;
            if (link.ann_valid) begin
                link.ack_mode <= link.ann_mode;
                if (link.ann_mode != MODE_NONE && link.ann_mode <= MODE_MAX)
                    decode_max_mode_o <= link.ann_mode;
            end
        end
    end

    // reports: requests, retries and answers to corrections
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link.report_valid <= 1'b0;
            link.report       <= '0;
            req_mode_reg      <= MODE_NONE;
            corr_o            <= 1'b0;
            corr_power_o      <= PWR_INC_ZERO;
            corr_timing_o     <= '0;
        end else begin
            link.report_valid <= 1'b0;
            corr_o            <= link.corr_valid;
            if (send_req)
                req_mode_reg <= req_mode_i;
            if (link.corr_valid) begin
                corr_power_o      <= link.corr_power;
                corr_timing_o     <= link.corr_timing;
                // answered whatever the flag says, so the access point timer always clears
                link.report       <= {(send_req ? req_mode_i : (rep_pending || rep_expired) ? req_mode_reg
                                                                                            : MODE_NONE),
                                      meas_i};
                link.report_valid <= 1'b1;
            end else if (send_req) begin
                link.report       <= {req_mode_i, meas_i};
                link.report_valid <= 1'b1;
            end else if (rep_expired && !link.ann_valid) begin
                link.report       <= {req_mode_reg, meas_i};
                link.report_valid <= 1'b1;
            end
        end
    end
endmodule : terminal_ctrl
`default_nettype wire

/* verification/link_adapt_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module link_adapt_chk (
    // clock and reset
    input  wire logic                                clk_i,
    input  wire logic                                resetn_i,
    // downlink messages
    input  wire logic                                ann_valid,
    input  wire logic [link_adapt_pkg::MODE_W-1:0]    ann_mode,
    input  wire logic                                corr_valid,
    input  wire logic [link_adapt_pkg::PWR_INC_W-1:0] corr_power,
    // uplink messages
    input  wire logic                                ack_valid,
    input  wire logic [link_adapt_pkg::MODE_W-1:0]    ack_mode,
    input  wire logic                                report_valid,
    input  wire logic [link_adapt_pkg::REPORT_W-1:0]  report
);
    import link_adapt_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_ann;
        ann_valid;
    endsequence
    sequence s_echo;
        ack_valid && ack_mode == $past(ann_mode);
    endsequence
    ack_echo_a: assert property (s_ann |=> s_echo) else $error("ack missing or mode differs");
    ann_mode_a: assert property (ann_valid |-> ann_mode >= MODE_ROBUST && ann_mode <= MODE_MAX)
        else $error("announced mode out of range");
    ack_cause_a: assert property (ack_valid |-> $past(ann_valid)) else $error("ack without announcement");
    report_mode_a: assert property (report_valid |-> report[REPORT_W-1 -: MODE_W] <= MODE_MAX)
        else $error("report wanted mode out of range");
    corr_range_a: assert property (corr_valid |-> corr_power <= PWR_INC_MAX)
        else $error("power step above limit");
    corr_answer_a: assert property (corr_valid |=> report_valid) else $error("correction not answered");
    ann_pulse_a: assert property (ann_valid |=> !ann_valid) else $error("announcement repeated too soon");
    corr_pulse_a: assert property (corr_valid |=> !corr_valid) else $error("correction repeated too soon");
    // handshake seen end to end
    handshake_c: cover property (s_ann ##1 s_echo);
endmodule // link_adapt_chk
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import link_adapt_pkg::*;
    logic                   clk_i, resetn_i, busy_o, report_o, corr_o, seen;
    logic                   cmd_mode_valid_i, cmd_corr_valid_i, cmd_corr_report_req_i, ranging_i;
    logic                   preamble_i, robust_short_i, req_valid_i;
    logic [MODE_W-1:0]      cmd_mode_i, req_mode_i, current_mode_o, decode_max_mode_o, cur;
    logic [PWR_INC_W-1:0]   cmd_corr_power_i, corr_power_o, lo, ep;
    logic [TIMING_W-1:0]    cmd_corr_timing_i, corr_timing_o;
    logic [TIMER_W-1:0]     timeout;
    logic [DL_PWR_W-1:0]    dl_power_target_i, threshold_gap_i, dl_power_o;
    logic [REPORT_W-1:0]    report_data_o;
    logic [REPORT_W-MODE_W-1:0] meas_i;
    int                     errors, total_checks;
    logic [MODE_W-1:0]      ack_q[$];
    logic [10:0]            corr_q[$];
    logic [REPORT_W-1:0]    rep_q[$];
    link_adapt_if link ();
    access_point_ctrl #(.DL_WINDOW(200)) i_access_point_ctrl (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
        .cmd_mode_valid_i(cmd_mode_valid_i), .cmd_mode_i(cmd_mode_i), .ack_timeout_i(timeout),
        .cmd_corr_valid_i(cmd_corr_valid_i), .cmd_corr_power_i(cmd_corr_power_i),
        .cmd_corr_timing_i(cmd_corr_timing_i), .cmd_corr_report_req_i(cmd_corr_report_req_i),
        .ranging_i(ranging_i), .corr_timeout_i(timeout), .preamble_i(preamble_i),
        .robust_short_i(robust_short_i), .dl_power_target_i(dl_power_target_i),
        .threshold_gap_i(threshold_gap_i), .current_mode_o(current_mode_o), .busy_o(busy_o),
        .report_o(report_o), .report_data_o(report_data_o), .dl_power_o(dl_power_o));
    terminal_ctrl i_terminal_ctrl (.clk_i(clk_i), .resetn_i(resetn_i), .link(link), .req_valid_i(req_valid_i),
        .req_mode_i(req_mode_i), .meas_i(meas_i), .report_timeout_i(timeout),
        .decode_max_mode_o(decode_max_mode_o), .corr_o(corr_o), .corr_power_o(corr_power_o),
        .corr_timing_o(corr_timing_o));
    link_adapt_chk i_link_adapt_chk (.clk_i(clk_i), .resetn_i(resetn_i), .ann_valid(link.ann_valid),
        .ann_mode(link.ann_mode), .corr_valid(link.corr_valid), .corr_power(link.corr_power),
        .ack_valid(link.ack_valid), .ack_mode(link.ack_mode), .report_valid(link.report_valid),
        .report(link.report));
    always #12.5 clk_i = ~clk_i;
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
        total_checks++;
        if (e !== s) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // queued notes checked as each result shows up
    always @(posedge clk_i) begin
        if (resetn_i === 1'b1) begin
            if (link.ack_valid === 1'b1) begin
                chk("ack_pending", 1, ack_q.size() > 0);
                if (ack_q.size() > 0) chk("ack_mode", ack_q.pop_front(), link.ack_mode);
            end
            if (corr_o === 1'b1) begin
                chk("corr_pending", 1, corr_q.size() > 0);
                if (corr_q.size() > 0) chk("corr_fields", corr_q.pop_front(), {corr_power_o, corr_timing_o});
            end
            if (report_o === 1'b1) begin
                chk("report_pending", 1, rep_q.size() > 0);
                if (rep_q.size() > 0) chk("report_data", rep_q.pop_front(), report_data_o);
            end
        end
    end
    task automatic mode_req(input logic [2:0] m, input logic ap, input logic spoil);
        logic [REPORT_W-MODE_W-1:0] mv;
        @(posedge clk_i);
        mv = 31'($urandom);
        meas_i <= mv;
        cmd_mode_valid_i <= ap;
        cmd_mode_i <= m;
        req_valid_i <= !ap;
        req_mode_i <= m;
        if (!ap && m >= 1 && m <= 4) rep_q.push_back({m, mv});
        if (m >= 1 && m <= 4) ack_q.push_back(m);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        cmd_mode_i <= 3'h4;
        if (spoil) @(posedge clk_i);
        cmd_mode_valid_i <= 1'b0;
        seen = 1'b0;
        for (int i = 0; i < 30; i++) begin
            @(negedge clk_i);
            if (busy_o === 1'b1 && !seen) begin
                seen = 1'b1;
                chk("mode_in_flight", (m < cur) ? m : cur, current_mode_o);
            end else if (busy_o !== 1'b1 && (seen || i > 12)) break;
        end
        if (m >= 1 && m <= 4) cur = m;
        chk("busy_seen", m >= 1 && m <= 4, seen);
        chk("granted_mode", cur, current_mode_o);
        chk("decode_max", cur, decode_max_mode_o);
        $display("test mode %0d from %0d done", m, ap);
    endtask
    task automatic pre(input int n);
        repeat (n) begin
            @(posedge clk_i);
            preamble_i <= 1'b1;
            @(posedge clk_i);
            preamble_i <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask
    initial begin
        {clk_i, resetn_i, cmd_mode_valid_i, cmd_corr_valid_i, cmd_corr_report_req_i, ranging_i} = '0;
        {preamble_i, robust_short_i, req_valid_i, cmd_mode_i, req_mode_i, meas_i} = '0;
        {cmd_corr_power_i, cmd_corr_timing_i, dl_power_target_i} = '0;
        {errors, total_checks} = '0;
        timeout = 24'h14;
        threshold_gap_i = 8'h03;
        cur = MODE_ROBUST;
        void'($urandom(80324));
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        mode_req(3'h3, 1'b0, 1'b0);
        mode_req(3'h1, 1'b0, 1'b0);
        mode_req(3'h2, 1'b1, 1'b1);
        mode_req(3'h4, 1'b1, 1'b0);
        chk("ack_q_empty", 0, ack_q.size());
        for (int k = 0; k < 4; k++) mode_req(k[0] ? 3'h7 : (k[1] ? 3'h5 : 3'h0), k[1], 1'b0);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            ep = 6'($urandom_range(0, 63));
            ranging_i <= k[0];
            cmd_corr_valid_i <= 1'b1;
            cmd_corr_power_i <= ep;
            cmd_corr_timing_i <= 5'($urandom_range(0, 16));
            cmd_corr_report_req_i <= k[1];
            lo = k[0] ? PWR_INC_MIN_RANGING : PWR_INC_MIN_NORMAL;
            ep = (ep < lo) ? lo : ((ep > PWR_INC_MAX) ? PWR_INC_MAX : ep);
            @(posedge clk_i);
            corr_q.push_back({ep, cmd_corr_timing_i});
            rep_q.push_back({MODE_NONE, meas_i});
            cmd_corr_valid_i <= 1'b0;
            repeat (8) @(posedge clk_i);
        end
        $display("test correction done");
        dl_power_target_i <= 8'h40;
        pre(2);
        chk("dl_no_need", 8'h00, dl_power_o);
        robust_short_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("dl_no_preamble", 8'h00, dl_power_o);
        pre(2);
        chk("dl_step", 8'h04, dl_power_o);
        pre(1);
        chk("dl_budget_spent", 8'h04, dl_power_o);
        repeat (210) @(posedge clk_i);
        pre(1);
        chk("dl_next_window", 8'h06, dl_power_o);
        $display("test dl power done");
        chk("queues_drained", 0, ack_q.size() + corr_q.size() + rep_q.size());
        results();
    end
    initial begin
        #(25 * 20000);
        errors++;
        $display("unexpected watchdog expected done seen hang");
        results();
    end
endmodule // tb_top
`default_nettype wire
